// File: rtds_cv_if.sv
// Purpose: Carries settings and results between the scanner modules.
// Assumes: One scheduler, one formatter, one top.
// Notes:   The formatted word is combinational from the held sample.
`default_nettype none

interface rtds_cv_if;
  logic [2:0]         n_act;
  logic               run;
  logic               fahr;
  logic               mag_sign;
  logic signed [15:0] raw;
  logic [15:0]        word;
  logic               res_valid;
  logic [1:0]         res_chan;
  logic [3:0]         res_fault;

  modport sched (input n_act, run, output raw, res_valid, res_chan,
                 res_fault);
  modport fmt   (input raw, fahr, mag_sign, output word);
  modport top   (output n_act, run, fahr, mag_sign,
                 input word, res_valid, res_chan, res_fault);
endinterface : rtds_cv_if

`default_nettype wire

// File: rtds_fe_model.sv
// Purpose: Front end model answering conversion requests.
// Assumes: One request outstanding at a time.
// Notes:   Latency is set by the bench, shorter or longer than a slot.
`default_nettype none

module rtds_fe_model
  import rtds_pkg::*;
(
  // Clock and link
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             fe_conv_req,
  input  wire logic [1:0]       fe_chan,
  input  wire logic [7:0]       lat,
  input  wire logic [3:0][15:0] temps,
  output var  logic             fe_conv_done,
  output var  logic [15:0]      fe_temp_c,
  output var  logic [3:0]       fe_fault
);
  logic [7:0] cnt;
  logic [1:0] ch;
  logic       fire;
  assign fire = rstn && !fe_conv_req && cnt == 8'h1;

  // one sample per request
  // Data toggles outside the done cycle, so a late sample shows up.
  always @(posedge clk)
  begin
    fe_conv_done <= fire;
    fe_temp_c    <= fire || !rstn ? temps[ch] : ~fe_temp_c;
    fe_fault     <= fire || !rstn ? 4'(1 << ch) : ~fe_fault;
    ch           <= !rstn ? 2'h0 : fe_conv_req ? fe_chan : ch;
    if (!rstn || fire)
      cnt <= 8'h0;
    else if (fe_conv_req)
      cnt <= lat;
    else if (cnt != 8'h0)
      cnt <= cnt - 8'h1;
  end
endmodule : rtds_fe_model

`default_nettype wire

// File: rtds_fmt.sv
// Purpose: Turns a Celsius sample into the reported data word.
// Assumes: Input is signed tenths of a degree Celsius.
// Notes:   Pure logic; no state.
`default_nettype none

module rtds_fmt
  import rtds_pkg::*;
(
  // Settings and sample
  rtds_cv_if.fmt cv
);
`include "rtds_params.svh"

  logic signed [31:0] c32;
  logic signed [31:0] t;
  logic signed [31:0] mag;
  logic               neg;

  always_comb
  begin
    c32 = {{16{cv.raw[15]}}, cv.raw};
    t = cv.fahr ? (c32 * `RTDS_F_MUL) / `RTDS_F_DIV + `RTDS_F_OFS : c32;
    neg = t < 32'sh0;
    mag = neg ? -t : t;
    // Saturation keeps the sign bit free in both formats.
    if (mag > `RTDS_MAG_MAX)
      mag = `RTDS_MAG_MAX;
    if (cv.mag_sign)
      cv.word = {neg, mag[14:0]};
    else
      cv.word = neg ? 16'(-mag) : mag[15:0];
  end

endmodule : rtds_fmt

`default_nettype wire

// File: rtds_params.svh
// Purpose: Constants of the temperature input scanner.
// Assumes: 100 MHz clock, byte addresses on the register port.
// Notes:   Included by the formatter, the top module, the checker and the bench.
`ifndef RTDS_PARAMS_SVH
`define RTDS_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define RTDS_CTRL_OFS     8'h00
`define RTDS_STAT_OFS     8'h04
`define RTDS_RES0_OFS     8'h10
`define RTDS_RES1_OFS     8'h14
`define RTDS_RES2_OFS     8'h18
`define RTDS_RES3_OFS     8'h1c
`define RTDS_CTRL_PTR_BIT 0
`define RTDS_CTRL_RUN_BIT 1
`define RTDS_CTRL_RST_PTR 1'h0
`define RTDS_CTRL_RST_RUN 1'h1

// ****************************************************************
// Input image layout
// ****************************************************************
`define RTDS_IMG_CHID_LSB 16
`define RTDS_IMG_FLT_LSB  18

// ****************************************************************
// Conversion and timing
// ****************************************************************
`define RTDS_F_OFS        32'sh140
`define RTDS_F_MUL        32'sh9
`define RTDS_F_DIV        32'sh5
`define RTDS_MAG_MAX      32'sh7fff
`define RTDS_SLOT_MS      160
`define RTDS_CLK_MHZ      100

`endif

// File: rtds_pkg.sv
// Purpose: Types shared by the temperature input scanner modules.
// Assumes: Nothing beyond the parameter header.
// Notes:   Holds types and the channel stepping function.
`default_nettype none

package rtds_pkg;

  typedef enum logic [2:0] {
    SNS_CU10   = 3'h0,
    SNS_CU25   = 3'h1,
    SNS_JPT100 = 3'h2,
    SNS_PT100  = 3'h3,
    SNS_PT1000 = 3'h4
  } rtds_sensor_t;

  typedef enum logic [1:0] {
    ST_REQ  = 2'b01,
    ST_BUSY = 2'b10
  } rtds_state_t;

  typedef struct packed {
    rtds_state_t        st;
    logic [31:0]        timer;
    logic [1:0]         chan;
    logic               req;
    logic               got;
    logic signed [15:0] raw;
    logic [3:0]         fault;
    logic               valid;
  } rtds_sched_st_t;

  typedef struct packed {
    logic [2:0]       n_act;
    rtds_sensor_t     sensor;
    logic             fahr;
    logic             mag_sign;
    logic             ptr_mode;
    logic             run;
    logic [3:0][31:0] res;
    logic [1:0]       mux;
    logic             burst;
    logic [1:0]       idx;
    logic [31:0]      img;
    logic             img_v;
    logic [31:0]      rdata;
  } rtds_top_st_t;

  // Next active channel, wrapping to the first after the last.
  function automatic logic [1:0] rtds_chan_next(input logic [1:0] cur,
                                                input logic [2:0] n_act);
    logic [2:0] nx;
    nx = {1'b0, cur} + 3'h1;
    if (nx >= n_act)
      return 2'h0;
    return nx[1:0];
  endfunction : rtds_chan_next

endpackage : rtds_pkg

`default_nettype wire

// File: rtds_scanner.sv
// Purpose: Four channel temperature input scanner with host image port.
// Assumes: Straps are steady levels; installed reads as one.
// Notes:   Straps are caught while reset is held.
//
// Operation
// - Two straps select one to four channels.
// - Both count straps installed give four channels.
// - Channels past the count are neither converted nor reported.
// - Three type straps decode the sensor type.
// - One sensor type serves every channel.
// - Default type is European platinum 100 ohm; with no type strap installed the code picks copper 10 ohm.
// - Two unit straps select format and scale.
// - Default is magnitude plus sign, Fahrenheit; with no unit strap installed the code gives two's complement Celsius.
// - Values are tenths of a degree.
// - Negative values set the data MSB.
// - Negatives follow the selected format.
// - Multiplexed mode gives one channel per scan.
// - Multiplexed mode steps active channels and wraps.
// - Pointer mode gives all active channels per scan.
// - Conversion runs apart from the host scan.
// - Reading latency is slots times count plus scan.
// - Image holds data, sign, channel id, faults.
//
// Decided for this implementation: the register offsets and the strobed register port.
`include "rtds_params.svh"
`default_nettype none

module rtds_scanner
  import rtds_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = `RTDS_SLOT_MS * 1000 * `RTDS_CLK_MHZ
)
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Straps
  input  wire logic          chan_count_strap_lo,
  input  wire logic          chan_count_strap_hi,
  input  wire logic          sensor_type_strap_b0,
  input  wire logic          sensor_type_strap_b1,
  input  wire logic          sensor_type_strap_b2,
  input  wire logic          unit_strap_b0,
  input  wire logic          unit_strap_b1,
  // Register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output var  logic [31:0]   reg_rdata,
  // Host scan
  input  wire logic          host_scan,
  output var  logic [31:0]   img_word,
  output var  logic          img_valid,
  // Front end
  output var  logic          fe_conv_req,
  output var  logic [1:0]    fe_chan,
  output var  logic [2:0]    fe_sensor_type,
  input  wire logic          fe_conv_done,
  input  wire logic [15:0]   fe_temp_c,
  input  wire logic [3:0]    fe_fault
);

  rtds_top_st_t s_r;
  rtds_top_st_t s_nxt;
  rtds_cv_if    cv ();

  // ****************************************************************
  // Conversion path
  // ****************************************************************
  rtds_sched #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_sched (
    .clk      (clk),
    .rstn     (rstn),
    .cv       (cv),
    .fe_req   (fe_conv_req),
    .fe_chan  (fe_chan),
    .fe_done  (fe_conv_done),
    .fe_temp  (fe_temp_c),
    .fe_fault (fe_fault)
  );

  rtds_fmt u_fmt (
    .cv (cv)
  );

  assign cv.n_act    = s_r.n_act;
  assign cv.run      = s_r.run;
  assign cv.fahr     = s_r.fahr;
  assign cv.mag_sign = s_r.mag_sign;

  // ****************************************************************
  // Strap decode
  // ****************************************************************
  function automatic rtds_sensor_t sensor_decode(input logic b2,
                                                 input logic b1,
                                                 input logic b0);
    rtds_sensor_t s;
    unique case ({b1, b0})
      2'h0: s = SNS_CU10;
      2'h1: s = SNS_CU25;
      2'h2: s = SNS_JPT100;
      2'h3: s = SNS_PT100;
    endcase
    // The high strap wins so a stray low strap cannot pick copper.
    if (b2)
      s = SNS_PT1000;
    return s;
  endfunction : sensor_decode

  // ****************************************************************
  // State update
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.img_v = 1'b0;
    s_nxt.rdata = 32'h0;
    if (!rstn)
    begin
      s_nxt = '0;
      s_nxt.n_act = {1'b0, chan_count_strap_hi, chan_count_strap_lo}
                    + 3'h1;
      s_nxt.sensor = sensor_decode(sensor_type_strap_b2,
                                   sensor_type_strap_b1,
                                   sensor_type_strap_b0);
      s_nxt.mag_sign = unit_strap_b1;
      s_nxt.fahr = unit_strap_b0;
      s_nxt.ptr_mode = `RTDS_CTRL_RST_PTR;
      s_nxt.run = `RTDS_CTRL_RST_RUN;
    end
    else
    begin
      if (cv.res_valid)
      begin
        s_nxt.res[cv.res_chan] = 32'h0;
        s_nxt.res[cv.res_chan][15:0] = cv.word;
        s_nxt.res[cv.res_chan][`RTDS_IMG_CHID_LSB +: 2] = cv.res_chan;
        s_nxt.res[cv.res_chan][`RTDS_IMG_FLT_LSB +: 4] = cv.res_fault;
      end

      if (s_r.burst)
      begin
        s_nxt.img = s_r.res[s_r.idx];
        s_nxt.img_v = 1'b1;
        if ({1'b0, s_r.idx} == s_r.n_act - 3'h1)
          s_nxt.burst = 1'b0;
        else
          s_nxt.idx = s_r.idx + 2'h1;
      end
      else if (host_scan)
      begin
        s_nxt.img_v = 1'b1;
        if (s_r.ptr_mode)
        begin
          s_nxt.img = s_r.res[0];
          if (s_r.n_act > 3'h1)
          begin
            s_nxt.burst = 1'b1;
            s_nxt.idx = 2'h1;
          end
        end
        else
        begin
          s_nxt.img = s_r.res[s_r.mux];
          s_nxt.mux = rtds_chan_next(s_r.mux, s_r.n_act);
        end
      end

      if (reg_wr && reg_addr == `RTDS_CTRL_OFS)
      begin
        s_nxt.ptr_mode = reg_wdata[`RTDS_CTRL_PTR_BIT];
        s_nxt.run = reg_wdata[`RTDS_CTRL_RUN_BIT];
        // Any control register write restarts the multiplexed walk at channel one.
        s_nxt.mux = 2'h0;
      end

      if (reg_rd)
      begin
        unique case (reg_addr)
          `RTDS_CTRL_OFS:
          begin
            s_nxt.rdata[`RTDS_CTRL_PTR_BIT] = s_r.ptr_mode;
            s_nxt.rdata[`RTDS_CTRL_RUN_BIT] = s_r.run;
          end
          `RTDS_STAT_OFS:
            s_nxt.rdata[11:0] = {cv.res_chan, s_r.mux, s_r.fahr,
                                 s_r.mag_sign, s_r.sensor, s_r.n_act};
          `RTDS_RES0_OFS: s_nxt.rdata = s_r.res[0];
          `RTDS_RES1_OFS:
            s_nxt.rdata = (s_r.n_act > 3'h1) ? s_r.res[1] : 32'h0;
          `RTDS_RES2_OFS:
            s_nxt.rdata = (s_r.n_act > 3'h2) ? s_r.res[2] : 32'h0;
          `RTDS_RES3_OFS:
            s_nxt.rdata = (s_r.n_act > 3'h3) ? s_r.res[3] : 32'h0;
          default: s_nxt.rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    s_r <= s_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // one type for all
  assign fe_sensor_type = s_r.sensor;
  assign img_word       = s_r.img;
  assign img_valid      = s_r.img_v;
  assign reg_rdata      = s_r.rdata;

endmodule : rtds_scanner

`default_nettype wire

// File: rtds_scanner_checker.sv
// Purpose: Pin checks of the temperature input scanner.
// Assumes: Straps are steady while reset is held.
// Notes:   Bound to the top module below.
`include "rtds_params.svh"
`default_nettype none

module rtds_scanner_checker
  import rtds_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = 20
)
(
  // Clock, straps, registers
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        chan_count_strap_lo,
  input wire logic        chan_count_strap_hi,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Host and front end
  input wire logic        host_scan,
  input wire logic [31:0] img_word,
  input wire logic        img_valid,
  input wire logic        fe_conv_req,
  input wire logic [1:0]  fe_chan
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [2:0]  n_r;
  logic        ptr_r, run_r;
  logic [1:0]  mux_r, req_r, ch;
  logic [31:0] gap_r;
  assign ch = img_word[17:16];

  // The gap saturates, so the first slot after reset always passes.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      n_r   <= 3'({chan_count_strap_hi, chan_count_strap_lo}) + 3'h1;
      ptr_r <= 1'b0;
      run_r <= `RTDS_CTRL_RST_RUN;
      mux_r <= 2'h0;
      req_r <= 2'h0;
      gap_r <= 32'hffffffff;
    end
    else
    begin
      if (reg_wr && reg_addr == `RTDS_CTRL_OFS)
      begin
        ptr_r <= reg_wdata[`RTDS_CTRL_PTR_BIT];
        run_r <= reg_wdata[`RTDS_CTRL_RUN_BIT];
        mux_r <= 2'h0;
      end
      else if (img_valid && !ptr_r)
        mux_r <= 3'(mux_r) + 3'h1 >= n_r ? 2'h0 : mux_r + 2'h1;
      if (fe_conv_req)
        req_r <= 3'(req_r) + 3'h1 >= n_r ? 2'h0 : req_r + 2'h1;
      gap_r <= fe_conv_req ? 32'h1 : gap_r + 32'(gap_r != 32'hffffffff);
    end
  end

  chk_req_range:
    assert property (fe_conv_req |-> 3'(fe_chan) < n_r)
    else $error("inactive channel converted");
  chk_req_order:
    assert property (fe_conv_req |-> fe_chan == req_r)
    else $error("conversion order wrong");
  chk_slot_gap:
    assert property (fe_conv_req |-> gap_r >= SLOT_CYCLES)
    else $error("conversions too close");
  chk_run_gate:
    assert property (fe_conv_req |-> $past(run_r))
    else $error("conversion started while stopped");
  chk_mux_single:
    assert property ((host_scan && !ptr_r) ##1 !host_scan |->
                     img_valid ##1 !img_valid)
    else $error("scan did not give one word");
  chk_mux_step:
    assert property (img_valid && !ptr_r |-> ch == mux_r)
    else $error("multiplexed channel out of order");
  chk_ptr_first:
    assert property (host_scan && ptr_r && !img_valid |=>
                     img_valid && ch == 2'h0)
    else $error("burst did not start at first channel");
  chk_ptr_next:
    assert property (img_valid && ptr_r && 3'(ch) + 3'h1 < n_r |=>
                     img_valid && ch == $past(ch) + 2'h1)
    else $error("burst skipped a channel");
  chk_img_layout:
    assert property (img_valid |-> img_word[31:22] == 10'h0 && 3'(ch) < n_r)
    else $error("image word malformed");

  cover property (img_valid && ptr_r && ch == 2'h3);
  cover property (img_valid && !ptr_r && mux_r == 2'h0 && n_r > 3'h1);
  cover property (fe_conv_req && gap_r > 32'h20);
endmodule : rtds_scanner_checker

bind rtds_scanner rtds_scanner_checker #(.SLOT_CYCLES(SLOT_CYCLES)) chk_u (
  .clk, .rstn, .chan_count_strap_lo, .chan_count_strap_hi, .reg_addr,
  .reg_wdata, .reg_wr, .host_scan, .img_word, .img_valid, .fe_conv_req,
  .fe_chan
);

`default_nettype wire

// File: rtds_scanner_tb_top.sv
// Purpose: Self-checking bench of the temperature input scanner.
// Assumes: Short slot; the front end model answers every request.
// Notes:   Every strap set is applied under its own reset.
`include "rtds_params.svh"
`default_nettype none

module rtds_scanner_tb_top
  import rtds_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int          SLOT = 20;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic [6:0]       strap = 7'h0;
  logic [7:0]       reg_addr = 8'h0;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic             host_scan = 1'b0;
  logic [7:0]       lat = 8'h3;
  logic [3:0][15:0] temps = {16'hfe70, 16'hf830, 16'hff06, 16'h03ea};
  logic [2:0]       typ [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
  logic [31:0]      reg_rdata, img_word, rv;
  logic             img_valid, fe_conv_req, fe_conv_done;
  logic [1:0]       fe_chan;
  logic [2:0]       fe_sensor_type, sx;
  logic [15:0]      fe_temp_c;
  logic [3:0]       fe_fault;
  int               n;
  int               err_count = 0;
  int               n_compared = 0;
  int               n_req = 0;

  always #5 clk = ~clk;

  // Counts conversion requests, so a stopped scanner can be seen idle.
  always @(posedge clk)
    if (fe_conv_req)
      n_req <= n_req + 1;

  rtds_scanner #(.SLOT_CYCLES(SLOT)) dut_u (
    .clk, .rstn, .chan_count_strap_lo(strap[0]),
    .chan_count_strap_hi(strap[1]), .sensor_type_strap_b0(strap[2]),
    .sensor_type_strap_b1(strap[3]), .sensor_type_strap_b2(strap[4]),
    .unit_strap_b0(strap[5]), .unit_strap_b1(strap[6]), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .host_scan, .img_word,
    .img_valid, .fe_conv_req, .fe_chan, .fe_sensor_type, .fe_conv_done,
    .fe_temp_c, .fe_fault
  );
  rtds_fe_model fe_u (
    .clk, .rstn, .fe_conv_req, .fe_chan, .lat, .temps, .fe_conv_done,
    .fe_temp_c, .fe_fault
  );

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] exp_word(input int c);
    int t;
    logic [15:0] d;
    t = $signed(temps[c]);
    if (strap[5])
      t = t * `RTDS_F_MUL / `RTDS_F_DIV + `RTDS_F_OFS;
    d = strap[6] ? {t < 0, 15'(t < 0 ? -t : t)} : 16'(t);
    return {10'h0, 4'(1 << c), 2'(c), d};
  endfunction : exp_word

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 check("reg", reg_rdata & m, e);
  endtask : rd

  // Words must come on consecutive cycles, then valid must drop.
  task automatic scan(input int first, input int cnt);
    @(posedge clk);
    host_scan <= 1'b1;
    @(posedge clk);
    host_scan <= 1'b0;
    for (int k = 0; k < cnt; k++)
    begin
      #1 check("valid", 32'(img_valid), 32'h1);
      check("image", img_word, exp_word((first + k) % n));
      @(posedge clk);
    end
    #1 check("idle", 32'(img_valid), 32'h0);
  endtask : scan

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      n = i % 4 + 1;
      rstn  <= 1'b0;
      strap <= {2'(i % 4), typ[i], 2'(n - 1)};
      lat   <= i % 2 ? 8'h1e : 8'h3;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      sx = typ[i][2] ? 3'h4 : typ[i];
      #1 check("sensor", 32'(fe_sensor_type), 32'(sx));
      repeat (n * (int'(lat) + SLOT + 4)) @(posedge clk);
      rv = {24'h0, strap[5], strap[6], sx, 3'(n)};
      rd(`RTDS_STAT_OFS, 32'hff, rv);
      rd(`RTDS_CTRL_OFS, ALL, 32'h2);
      rd(8'h08, ALL, 32'h0);
      rd(`RTDS_RES0_OFS + 8'(4 * n - 4), ALL, exp_word(n - 1));
      rd(`RTDS_RES3_OFS, ALL, n == 4 ? exp_word(3) : 32'h0);
      for (int k = 0; k <= n; k++)
        scan(k % n, 1);
      wr(`RTDS_CTRL_OFS, 32'h3);
      scan(0, n);
      wr(`RTDS_CTRL_OFS, 32'h1);
      rd(`RTDS_CTRL_OFS, ALL, 32'h1);
      repeat (int'(lat) + SLOT + 8) @(posedge clk);
      #1 rv = 32'(n_req);
      repeat (2 * SLOT) @(posedge clk);
      #1 check("stopped", 32'(n_req), rv);
      $display("config %0d done", i);
    end
    final_report();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule : rtds_scanner_tb_top

`default_nettype wire

// File: rtds_sched.sv
// Purpose: Paces conversions over the active channels, apart from scans.
// Assumes: Front end answers a request with one done pulse.
// Notes:   A slot lasts the longer of the slot time and the conversion.
`default_nettype none

module rtds_sched
  import rtds_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = 16000000
)
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Link to top
  rtds_cv_if.sched           cv,
  // Front end
  output var  logic          fe_req,
  output var  logic [1:0]    fe_chan,
  input  wire logic          fe_done,
  input  wire logic [15:0]   fe_temp,
  input  wire logic [3:0]    fe_fault
);

  rtds_sched_st_t s_r;
  rtds_sched_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.req = 1'b0;
    s_nxt.valid = 1'b0;
    if (!rstn)
    begin
      s_nxt = '0;
      s_nxt.st = ST_REQ;
    end
    else
    begin
      unique case (s_r.st)
        ST_REQ:
        begin
          if (cv.run)
          begin
            s_nxt.req = 1'b1;
            s_nxt.timer = 32'h0;
            s_nxt.got = 1'b0;
            s_nxt.st = ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          if (s_r.timer != SLOT_CYCLES - 1)
            s_nxt.timer = s_r.timer + 32'h1;
          if (fe_done && !s_r.got)
          begin
            s_nxt.got = 1'b1;
            s_nxt.raw = signed'(fe_temp);
            s_nxt.fault = fe_fault;
            s_nxt.valid = 1'b1;
          end
          if (s_r.got && s_r.timer == SLOT_CYCLES - 1)
          begin
            s_nxt.chan = rtds_chan_next(s_r.chan, cv.n_act);
            s_nxt.st = ST_REQ;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    s_r <= s_nxt;
  end

  assign fe_req       = s_r.req;
  assign fe_chan      = s_r.chan;
  assign cv.raw       = s_r.raw;
  assign cv.res_valid = s_r.valid;
  assign cv.res_chan  = s_r.chan;
  assign cv.res_fault = s_r.fault;

endmodule : rtds_sched

`default_nettype wire
